// *** core/spp_pkg.sv ***
package spp_pkg;

    // Register byte addresses on the CPU port.
    localparam logic [15:0] ADDR_CTRL1 = 16'h00d0;
    localparam logic [15:0] ADDR_BAUD = 16'h00d2;
    localparam logic [15:0] ADDR_STATUS = 16'h00d3;
    localparam logic [15:0] ADDR_DATA = 16'h00d5;
    localparam logic [15:0] ADDR_PORT = 16'h00d6;
    localparam logic [15:0] ADDR_DIR = 16'h00d7;
    localparam logic [15:0] ADDR_PURD = 16'h00db;

    // Bit positions in spi_control_one.
    localparam int CR1_SPI_IRQ_ENABLE = 7;
    localparam int CR1_SPE = 6;
    localparam int CR1_SWOM = 5;
    localparam int CR1_MASTER_SELECT = 4;
    localparam int CR1_CPOL = 3;
    localparam int CR1_CPHA = 2;
    localparam int CR1_SSOE = 1;
    localparam int CR1_LSBF = 0;

    // Bit positions in port_pullup_drive_ctrl.
    localparam int PD_LOW_HI = 6;
    localparam int PD_LOW_MID = 5;
    localparam int PD_LOW_LO = 4;
    localparam int PD_PU_HI = 2;
    localparam int PD_PU_MID = 1;
    localparam int PD_PU_LO = 0;

    // Pin positions of the shared functions.
    localparam int PIN_SS = 7;
    localparam int PIN_SCK = 6;
    localparam int PIN_MOSI = 5;
    localparam int PIN_MISO = 4;
    localparam int PIN_TXD = 1;
    localparam int PIN_RXD = 0;

    // Reset values and writable masks.
    localparam logic [7:0] CTRL1_RST = 8'h04;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] BAUD_MASK = 8'h07;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] PURD_RST = 8'h07;
    localparam logic [7:0] PURD_MASK = 8'h77;
    localparam logic [7:0] PIN_IDLE = 8'hff;

    // Sixteen clock edges carry one byte; the last edge ends it.
    localparam logic [3:0] LAST_EDGE = 4'hf;

    typedef enum {SPP_IDLE, SPP_RUN} spp_state_t;

endpackage

// *** core/spp_port.sv ***
// Operation
// - Master with slave-select low sets mode fault.
// - Pin 7 output blocks and clears mode fault.
// - Status read then control write clears fault.
// - Data reads buffered; idle writes load shifter directly.
// - Eight shifts exchange bytes through shared ring.
// - Reset leaves SPI data contents untouched.
// - Port read: inputs show pin, outputs latch.
// - Port writes never move serially driven pins.
// - Reset clears all direction bits.
// - Direction bit one drives, zero inputs.
// - Two-wire serial forces receive in, transmit out.
// - SPI inputs forced; SPI outputs need direction.
// - Slave: pin 7 select; master: direction chooses.
// - Pins 2 and 3 are plain I/O.
// - Three group bits reduce output drive.
// - Three group pull-ups, off for outputs.
// - Mode fault forces enable to read zero.
// - Interrupt on transfer done or mode fault.
// - Slave output needs direction, select low, slave.
`timescale 1ns/100ps
module spp_port (
    input wire logic clock,
    input wire logic reset,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    input wire logic [7:0] ps_in,
    output logic [7:0] ps_out,
    output logic [7:0] ps_oe,
    output logic [7:0] ps_pullup,
    output logic [7:0] ps_low_drive,
    input wire logic sci_tx_en,
    input wire logic sci_rx_en,
    input wire logic sci_txd,
    output logic sci_rxd,
    output logic spi_irq
);

    ////////////////////////////////////////////////////////////////////////
    // Bit position of serial bit k, honouring the bit order select.
    function automatic logic [2:0] bit_pos(input logic [2:0] k,
                                           input logic lsbf);
        bit_pos = lsbf ? k : 3'h7 - k;
    endfunction

    logic [7:0] sync1_r, sync2_r, sync3_r, pin_f_r, pin_f_nxt;
    logic [7:0] ctrl1_r, ctrl1_nxt, baud_r, baud_nxt, dir_r, dir_nxt;
    logic [7:0] purd_r, purd_nxt, port_r, port_nxt;
    logic transfer_complete_flag_r, transfer_complete_flag_nxt, wcol_r, wcol_nxt, mode_fault_flag_r, mode_fault_flag_nxt;
    logic transfer_complete_flag_seen_r, transfer_complete_flag_seen_nxt, wcol_seen_r, wcol_seen_nxt;
    logic mode_fault_flag_seen_r, mode_fault_flag_seen_nxt;
    spp_pkg::spp_state_t state_r, state_nxt;
    logic [3:0] edge_r, edge_nxt;
    logic [7:0] div_r, div_nxt, half;
    logic sck_r, sck_nxt, out_r, out_nxt, sck_seen_r, sck_seen_nxt;
    logic [7:0] shift_r, shift_nxt, rxbuf_r, rxbuf_nxt;
    logic [7:0] out_pins_nxt, oe_pins_nxt, pu_nxt, low_nxt, rd_nxt;
    logic spe_eff, master_select, master_on, slave_on, ss_in, in_bit, lsbf, cpha;
    logic data_acc, wr_dreg, wr_ctrl1, rd_status, edge_hit, done;
    logic mode_fault_flag_set, busy;

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs pass three flops; a change counts when stages two and
    // three agree, which rejects a single-cycle glitch on a slow line.
    always_comb begin
        pin_f_nxt = ((sync2_r ~^ sync3_r) & sync3_r)
                  | ((sync2_r ^ sync3_r) & pin_f_r);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_r <= spp_pkg::PIN_IDLE;
            sync2_r <= spp_pkg::PIN_IDLE;
            sync3_r <= spp_pkg::PIN_IDLE;
            pin_f_r <= spp_pkg::PIN_IDLE;
        end else begin
            sync1_r <= ps_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_f_r <= pin_f_nxt;
        end
    end

    // Decoded access strobes and effective operating mode.
    assign data_acc = (wr_stb | rd_stb) && addr == spp_pkg::ADDR_DATA;
    assign wr_dreg = wr_stb && addr == spp_pkg::ADDR_DATA;
    assign wr_ctrl1 = wr_stb && addr == spp_pkg::ADDR_CTRL1;
    assign rd_status = rd_stb && addr == spp_pkg::ADDR_STATUS;
    assign spe_eff = ctrl1_r[spp_pkg::CR1_SPE] & ~mode_fault_flag_r;
    assign master_select = ctrl1_r[spp_pkg::CR1_MASTER_SELECT];
    assign master_on = spe_eff & master_select;
    assign slave_on = spe_eff & ~master_select;
    assign lsbf = ctrl1_r[spp_pkg::CR1_LSBF];
    assign cpha = ctrl1_r[spp_pkg::CR1_CPHA];
    assign ss_in = pin_f_r[spp_pkg::PIN_SS];
    assign busy = state_r == spp_pkg::SPP_RUN;
    assign mode_fault_flag_set = ctrl1_r[spp_pkg::CR1_SPE] & master_select
                    & ~dir_r[spp_pkg::PIN_SS] & ~ss_in;
    assign spi_irq = ctrl1_r[spp_pkg::CR1_SPI_IRQ_ENABLE] & (transfer_complete_flag_r | mode_fault_flag_r);
    assign sci_rxd = pin_f_r[spp_pkg::PIN_RXD];

    ////////////////////////////////////////////////////////////////////////
    // Software registers and the status flags. A hardware set always
    // wins over a clear in the same cycle, so no event is lost.
    always_comb begin
        ctrl1_nxt = wr_ctrl1 ? wr_data : ctrl1_r;
        baud_nxt = baud_r;
        dir_nxt = dir_r;
        purd_nxt = purd_r;
        port_nxt = port_r;
        if (wr_stb && addr == spp_pkg::ADDR_BAUD) begin
            baud_nxt = wr_data & spp_pkg::BAUD_MASK;
        end
        if (wr_stb && addr == spp_pkg::ADDR_DIR) begin
            dir_nxt = wr_data;
        end
        if (wr_stb && addr == spp_pkg::ADDR_PURD) begin
            purd_nxt = wr_data & spp_pkg::PURD_MASK;
        end
        if (wr_stb && addr == spp_pkg::ADDR_PORT) begin
            port_nxt = wr_data;
        end
        transfer_complete_flag_seen_nxt = rd_status ? transfer_complete_flag_r : transfer_complete_flag_seen_r;
        wcol_seen_nxt = rd_status ? wcol_r : wcol_seen_r;
        mode_fault_flag_seen_nxt = rd_status ? mode_fault_flag_r : mode_fault_flag_seen_r;
        transfer_complete_flag_nxt = (transfer_complete_flag_r & ~(data_acc & transfer_complete_flag_seen_r)) | done;
        wcol_nxt = (wcol_r & ~(data_acc & wcol_seen_r)) | (wr_dreg & busy);
        if (data_acc) begin
            transfer_complete_flag_seen_nxt = 1'b0;
            wcol_seen_nxt = 1'b0;
        end
        mode_fault_flag_nxt = (mode_fault_flag_r & ~(wr_ctrl1 & mode_fault_flag_seen_r)) | mode_fault_flag_set;
        if (wr_ctrl1) begin
            mode_fault_flag_seen_nxt = 1'b0;
        end
        if (dir_r[spp_pkg::PIN_SS]) begin
            mode_fault_flag_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl1_r <= spp_pkg::CTRL1_RST;
            baud_r <= spp_pkg::BAUD_RST;
            dir_r <= spp_pkg::DIR_RST;
            purd_r <= spp_pkg::PURD_RST;
            transfer_complete_flag_r <= 1'b0;
            wcol_r <= 1'b0;
            mode_fault_flag_r <= 1'b0;
            transfer_complete_flag_seen_r <= 1'b0;
            wcol_seen_r <= 1'b0;
            mode_fault_flag_seen_r <= 1'b0;
        end else begin
            ctrl1_r <= ctrl1_nxt;
            baud_r <= baud_nxt;
            dir_r <= dir_nxt;
            purd_r <= purd_nxt;
            transfer_complete_flag_r <= transfer_complete_flag_nxt;
            wcol_r <= wcol_nxt;
            mode_fault_flag_r <= mode_fault_flag_nxt;
            transfer_complete_flag_seen_r <= transfer_complete_flag_seen_nxt;
            wcol_seen_r <= wcol_seen_nxt;
            mode_fault_flag_seen_r <= mode_fault_flag_seen_nxt;
        end
        port_r <= port_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift engine. Even edges are leading clock edges, odd ones trailing.
    // The outgoing bit is held in out_r so that sampling into the same
    // shifter position never disturbs the line before the shift edge.
    assign half = 8'h01 << baud_r[2:0];
    assign in_bit = master_select ? pin_f_r[spp_pkg::PIN_MISO]
                         : pin_f_r[spp_pkg::PIN_MOSI];
    assign edge_hit = busy && (master_select ? div_r == half - 8'h01
                                    : pin_f_r[spp_pkg::PIN_SCK] != sck_seen_r);
    assign done = edge_hit && edge_r == spp_pkg::LAST_EDGE;

    always_comb begin
        state_nxt = state_r;
        edge_nxt = edge_r;
        div_nxt = busy ? div_r + 8'h01 : 8'h00;
        sck_nxt = sck_r;
        sck_seen_nxt = pin_f_r[spp_pkg::PIN_SCK];
        out_nxt = out_r;
        shift_nxt = shift_r;
        rxbuf_nxt = rxbuf_r;
        if (wr_dreg && !busy) begin
            shift_nxt = wr_data;
            out_nxt = wr_data[bit_pos(3'h0, lsbf)];
        end
        if (!busy) begin
            sck_nxt = ctrl1_r[spp_pkg::CR1_CPOL];
            edge_nxt = 4'h0;
            if ((master_on && wr_dreg) || (slave_on && !ss_in)) begin
                state_nxt = spp_pkg::SPP_RUN;
            end
        end else if (!spe_eff || (!master_select && ss_in)) begin
            state_nxt = spp_pkg::SPP_IDLE; // Abort leaves shifter as is.
        end else if (edge_hit) begin
            div_nxt = 8'h00;
            sck_nxt = ~sck_r;
            edge_nxt = edge_r + 4'h1;
            if (edge_r[0] == cpha) begin
                shift_nxt[bit_pos(edge_r[3:1], lsbf)] = in_bit;
            end else begin
                out_nxt = shift_r[bit_pos(edge_r[3:1] + {2'h0, ~cpha}, lsbf)];
            end
            if (done) begin
                state_nxt = spp_pkg::SPP_IDLE;
                rxbuf_nxt = shift_nxt;
            end
        end
    end

    // Data holders take no reset, so a reset keeps their contents.
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= spp_pkg::SPP_IDLE;
            edge_r <= 4'h0;
            div_r <= 8'h00;
            sck_r <= 1'b0;
            out_r <= 1'b0;
            sck_seen_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            edge_r <= edge_nxt;
            div_r <= div_nxt;
            sck_r <= sck_nxt;
            out_r <= out_nxt;
            sck_seen_r <= sck_seen_nxt;
        end
        shift_r <= shift_nxt;
        rxbuf_r <= rxbuf_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin ownership. General-purpose use is the default; serial functions
    // then override. Wired-OR mode on the upper group releases a one.
    always_comb begin
        oe_pins_nxt = dir_r;
        out_pins_nxt = port_r;
        if (sci_rx_en) begin
            oe_pins_nxt[spp_pkg::PIN_RXD] = 1'b0;
        end
        if (sci_tx_en) begin
            oe_pins_nxt[spp_pkg::PIN_TXD] = 1'b1;
            out_pins_nxt[spp_pkg::PIN_TXD] = sci_txd;
        end
        if (master_on) begin
            oe_pins_nxt[spp_pkg::PIN_MISO] = 1'b0;
            out_pins_nxt[spp_pkg::PIN_MOSI] = out_r;
            out_pins_nxt[spp_pkg::PIN_SCK] = sck_r;
            if (!dir_r[spp_pkg::PIN_SS]) begin
                oe_pins_nxt[spp_pkg::PIN_SS] = 1'b0;
            end else if (ctrl1_r[spp_pkg::CR1_SSOE]) begin
                out_pins_nxt[spp_pkg::PIN_SS] = ~busy;
            end
        end else if (slave_on) begin
            oe_pins_nxt[spp_pkg::PIN_MOSI] = 1'b0;
            oe_pins_nxt[spp_pkg::PIN_SCK] = 1'b0;
            oe_pins_nxt[spp_pkg::PIN_SS] = 1'b0;
            oe_pins_nxt[spp_pkg::PIN_MISO] = dir_r[spp_pkg::PIN_MISO]
                                           & ~ss_in;
            out_pins_nxt[spp_pkg::PIN_MISO] = out_r;
        end
        if (ctrl1_r[spp_pkg::CR1_SWOM]) begin
            oe_pins_nxt[spp_pkg::PIN_SS:spp_pkg::PIN_MISO] =
                oe_pins_nxt[spp_pkg::PIN_SS:spp_pkg::PIN_MISO]
                & ~out_pins_nxt[spp_pkg::PIN_SS:spp_pkg::PIN_MISO];
        end
        low_nxt = {{4{purd_r[spp_pkg::PD_LOW_HI]}},
                   {2{purd_r[spp_pkg::PD_LOW_MID]}},
                   {2{purd_r[spp_pkg::PD_LOW_LO]}}};
        pu_nxt = {{4{purd_r[spp_pkg::PD_PU_HI]}},
                  {2{purd_r[spp_pkg::PD_PU_MID]}},
                  {2{purd_r[spp_pkg::PD_PU_LO]}}} & ~oe_pins_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer; data stands only in the cycle after the strobe.
    always_comb begin
        case (addr)
            spp_pkg::ADDR_CTRL1: begin
                rd_nxt = ctrl1_r;
                rd_nxt[spp_pkg::CR1_SPE] = spe_eff;
            end
            spp_pkg::ADDR_BAUD: rd_nxt = baud_r;
            spp_pkg::ADDR_STATUS: rd_nxt = {transfer_complete_flag_r, wcol_r, 1'b0, mode_fault_flag_r, 4'h0};
            spp_pkg::ADDR_DATA: rd_nxt = rxbuf_r;
            spp_pkg::ADDR_PORT: rd_nxt = (port_r & dir_r)
                                       | (pin_f_r & ~dir_r);
            spp_pkg::ADDR_DIR: rd_nxt = dir_r;
            spp_pkg::ADDR_PURD: rd_nxt = purd_r;
            default: rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rd_data <= 8'h00;
            ps_out <= 8'h00;
            ps_oe <= 8'h00;
            ps_pullup <= 8'h00;
            ps_low_drive <= 8'h00;
        end else begin
            rd_data <= rd_stb ? rd_nxt : 8'h00;
            ps_out <= out_pins_nxt;
            ps_oe <= oe_pins_nxt;
            ps_pullup <= pu_nxt;
            ps_low_drive <= low_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the behaviour above.
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_saw_mode_fault_flag;
        rd_status && mode_fault_flag_r;
    endsequence

    sequence s_ctrl_write;
        wr_ctrl1 && !mode_fault_flag_set && !rd_status;
    endsequence

    a_mode_fault_flag_sets: assert property (mode_fault_flag_set |=> mode_fault_flag_r)
        else $error("mode fault not raised");
    a_mode_fault_flag_pin7_out: assert property (dir_r[spp_pkg::PIN_SS] |=> !mode_fault_flag_r)
        else $error("mode fault set with pin 7 output");
    a_mode_fault_flag_recovery: assert property (s_saw_mode_fault_flag ##1 !wr_ctrl1
                                      ##1 s_ctrl_write |=> !mode_fault_flag_r)
        else $error("mode fault not cleared by recovery");
    a_spe_reads_zero: assert property (rd_stb && addr == spp_pkg::ADDR_CTRL1
        && mode_fault_flag_r |=> !rd_data[spp_pkg::CR1_SPE])
        else $error("enable read as one during mode fault");
    a_write_to_shift: assert property (wr_dreg && !busy
                                       |=> shift_r == $past(wr_data))
        else $error("data write did not load shifter");
    a_byte_done: assert property (done |=> transfer_complete_flag_r && !busy
                                  && rxbuf_r == $past(shift_nxt))
        else $error("byte end not flagged");
    a_port_read: assert property (rd_stb && addr == spp_pkg::ADDR_PORT
        |=> rd_data == $past((port_r & dir_r) | (pin_f_r & ~dir_r)))
        else $error("port read value wrong");
    a_tx_pin_out: assert property (sci_tx_en |=> ps_oe[spp_pkg::PIN_TXD]
                                   && ps_out[spp_pkg::PIN_TXD]
                                   == $past(sci_txd))
        else $error("transmit pin not driven");
    a_plain_pins: assert property (##1 ps_oe[3:2] == $past(dir_r[3:2]))
        else $error("pins 2 and 3 overridden");
    a_pullup_off: assert property ((ps_pullup & ps_oe) == 8'h00)
        else $error("pull-up on an output");
    a_slave_out: assert property (ps_oe[spp_pkg::PIN_MISO] && $past(slave_on)
        |-> $past(dir_r[spp_pkg::PIN_MISO]) && !$past(ss_in))
        else $error("slave output driven illegally");

endmodule // spp_port

// *** tb/spp_spi_peer.sv ***
`timescale 1ns/100ps
// Slave peer on the pins: clock mode 0, most significant bit first.
module spp_spi_peer (
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic miso_oe,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    logic in_bit;

    // Start from a known shifter so the first frame is not unknown.
    initial begin
        sh = 8'h00;
        in_bit = 1'h0;
        miso = 1'h0;
    end

    // Load on select; once released the line shows the inverse level.
    always @(ss_n) begin
        if (!ss_n) begin
            sh = tx_byte;
            miso = sh[7];
        end else begin
            miso = ~miso;
        end
    end

    // Sample on the leading edge and shift on the trailing one.
    always @(posedge sck) in_bit = mosi;
    always @(negedge sck) begin
        sh = {sh[6:0], in_bit};
        miso = sh[7];
    end

    // The peer drives its data line only while selected.
    assign miso_oe = ~ss_n;
    assign rx_byte = sh;
endmodule // spp_spi_peer

// *** tb/spp_port_tb.sv ***
`timescale 1ns/100ps
module spp_port_tb;
    logic clock, reset, wr_stb, rd_stb, sci_tx_en, sci_rx_en, sci_txd;
    logic [15:0] addr;
    logic [7:0] wr_data, rd_data, ps_out, ps_oe, ps_pullup, ps_low_drive;
    logic [7:0] ext_val, peer_tx, peer_rx, rv;
    logic sci_rxd, spi_irq, miso, miso_oe;
    wire logic [7:0] ps_in;
    int mismatches, comparisons, n;

    spp_port u_dut (.clock(clock), .reset(reset), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rd_data(rd_data), .ps_in(ps_in), .ps_out(ps_out), .ps_oe(ps_oe),
        .ps_pullup(ps_pullup), .ps_low_drive(ps_low_drive),
        .sci_tx_en(sci_tx_en), .sci_rx_en(sci_rx_en), .sci_txd(sci_txd),
        .sci_rxd(sci_rxd), .spi_irq(spi_irq));

    spp_spi_peer u_peer (.sck(ps_in[6]), .mosi(ps_in[5]), .ss_n(ps_in[7]),
        .tx_byte(peer_tx), .miso(miso), .miso_oe(miso_oe),
        .rx_byte(peer_rx));

    // Each pin level: device first, then the peer, then the outside level.
    assign ps_in = (ps_oe & ps_out) | (~ps_oe & (miso_oe ?
        {ext_val[7:5], miso, ext_val[3:0]} : ext_val));

    // Free-running system clock.
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end

    task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'h1;
        @(posedge clock);
        wr_stb <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe is taken.
    task rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge clock);
        rd_stb <= 1'h0;
        #1;
        d = rd_data;
    endtask

    task rdc(input logic [15:0] a, input logic [7:0] exp, input string nm);
        rd(a, rv);
        check(nm, rv, exp);
    endtask

    task waitc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    task results;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; pin inputs need several cycles through the filter.
    initial begin
        mismatches = 0;
        comparisons = 0;
        reset = 1'h1;
        {wr_stb, rd_stb, sci_tx_en, sci_rx_en, sci_txd} = 5'h00;
        addr = 16'h0000;
        wr_data = 8'h00;
        ext_val = 8'hff;
        peer_tx = 8'h96;
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        waitc(2);
        check("pullup", ps_pullup, 8'hff);
        check("oe", ps_oe, 8'h00);
        rdc(spp_pkg::ADDR_DIR, 8'h00, "dir");
        rdc(spp_pkg::ADDR_PURD, 8'h07, "purd");
        rdc(16'h00e0, 8'h00, "unmapped");
        // Plain pins 3:2 as outputs, the rest read their pin level.
        wr(spp_pkg::ADDR_DIR, 8'h0c);
        wr(spp_pkg::ADDR_PORT, 8'h08);
        ext_val <= 8'ha5;
        waitc(8);
        rdc(spp_pkg::ADDR_PORT, 8'ha9, "port");
        check("oe", ps_oe, 8'h0c);
        check("out", ps_out & 8'h0c, 8'h08);
        wr(spp_pkg::ADDR_PURD, 8'h47);
        waitc(2);
        check("lowdrv", ps_low_drive, 8'hf0);
        check("pullup", ps_pullup, 8'hf3);
        wr(spp_pkg::ADDR_PURD, 8'h30);
        waitc(2);
        check("lowdrv", ps_low_drive, 8'h0f);
        check("pullup", ps_pullup, 8'h00);
        // Serial unit borrows pins 1:0 against their direction bits.
        sci_tx_en <= 1'h1;
        sci_rx_en <= 1'h1;
        sci_txd <= 1'h0;
        wr(spp_pkg::ADDR_DIR, 8'h01);
        wr(spp_pkg::ADDR_PORT, 8'h02);
        waitc(8);
        check("sci oe", ps_oe & 8'h03, 8'h02);
        check("txd pin", {7'h00, ps_out[1]}, 8'h00);
        check("rxd", {7'h00, sci_rxd}, 8'h01);
        ext_val <= 8'ha4;
        waitc(8);
        check("rxd", {7'h00, sci_rxd}, 8'h00);
        sci_tx_en <= 1'h0;
        sci_rx_en <= 1'h0;
        wr(spp_pkg::ADDR_DIR, 8'h02);
        waitc(2);
        check("latch", {7'h00, ps_out[1]}, 8'h01);
        check("oe", ps_oe, 8'h02);
        // Master with select input pulled low is a mode fault.
        ext_val <= 8'h7f;
        wr(spp_pkg::ADDR_DIR, 8'h00);
        wr(spp_pkg::ADDR_CTRL1, 8'hd0);
        waitc(8);
        rdc(spp_pkg::ADDR_STATUS, 8'h10, "mode_fault_flag set");
        rdc(spp_pkg::ADDR_CTRL1, 8'h90, "spe read");
        check("irq", {7'h00, spi_irq}, 8'h01);
        ext_val <= 8'hff;
        waitc(8);
        rdc(spp_pkg::ADDR_STATUS, 8'h10, "mode_fault_flag held");
        wr(spp_pkg::ADDR_CTRL1, 8'h00);
        rdc(spp_pkg::ADDR_STATUS, 8'h00, "mode_fault_flag clr");
        check("irq", {7'h00, spi_irq}, 8'h00);
        ext_val <= 8'h7f;
        wr(spp_pkg::ADDR_DIR, 8'h80);
        wr(spp_pkg::ADDR_CTRL1, 8'h50);
        waitc(8);
        rdc(spp_pkg::ADDR_STATUS, 8'h00, "mode_fault_flag off");
        // Slave: pin 7 is the select input, data out needs it low.
        wr(spp_pkg::ADDR_CTRL1, 8'h40);
        wr(spp_pkg::ADDR_DIR, 8'h90);
        ext_val <= 8'hff;
        waitc(8);
        check("slave oe", ps_oe & 8'h90, 8'h00);
        ext_val <= 8'h7f;
        waitc(8);
        check("slave oe", ps_oe & 8'h90, 8'h10);
        // Master exchange with the peer; SCK half period is 8 clocks.
        wr(spp_pkg::ADDR_CTRL1, 8'h00);
        ext_val <= 8'hff;
        wr(spp_pkg::ADDR_BAUD, 8'h03);
        wr(spp_pkg::ADDR_DIR, 8'hf0);
        wr(spp_pkg::ADDR_CTRL1, 8'hd2);
        wr(spp_pkg::ADDR_DATA, 8'h3c);
        waitc(4);
        check("master oe", ps_oe & 8'hf0, 8'he0);
        check("ss out", {7'h00, ps_out[7]}, 8'h00);
        // A write while busy is dropped and raises the collision flag.
        wr(spp_pkg::ADDR_DATA, 8'h55);
        n = 0;
        rv = 8'h00;
        while (rv[7] !== 1'h1 && n < 200) begin
            rd(spp_pkg::ADDR_STATUS, rv);
            n++;
        end
        check("transfer_complete_flag", rv, 8'hc0);
        if (rv[7] !== 1'h1) begin
            results();
        end
        check("irq", {7'h00, spi_irq}, 8'h01);
        rdc(spp_pkg::ADDR_DATA, 8'h96, "rx data");
        check("peer rx", peer_rx, 8'h3c);
        rdc(spp_pkg::ADDR_STATUS, 8'h00, "transfer_complete_flag clr");
        // Writes go to the shifter, reads come from the receive buffer.
        wr(spp_pkg::ADDR_CTRL1, 8'h00);
        wr(spp_pkg::ADDR_DATA, 8'h3c);
        rdc(spp_pkg::ADDR_DATA, 8'h96, "buffered");
        @(posedge clock);
        reset <= 1'h1;
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        rdc(spp_pkg::ADDR_DATA, 8'h96, "data kept");
        rdc(spp_pkg::ADDR_DIR, 8'h00, "dir");
        results();
    end
endmodule // spp_port_tb
